/* File: sim/clt_capacity_tracker_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module clt_capacity_tracker_asserts
  import clt_pkg::*;
#(
  parameter int WB_CYCLES = WB_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic measTick,
  input wire logic init,
  input wire logic signed [CHG_W-1:0] chargeDelta,
  input wire logic signed [CUR_W-1:0] current,
  input wire logic signed [TEMP_W-1:0] temperature,
  input wire logic signed [TEMP_W-1:0] learnMinTemp,
  input wire logic [CUR_W-1:0] overloadCurrent,
  input wire logic [CAP_W-1:0] storedFullCap,
  input wire logic chargeTermination,
  input wire clt_cfg_s gaugingConfig,
  input wire logic [CAP_W-1:0] remainingChargeCount,
  input wire logic [CAP_W-1:0] learnedFullCapacityValue,
  input wire clt_status_s opStatusWord,
  input wire logic nvWriteStrobe
);
  wire [CAP_W-1:0] rc = remainingChargeCount;
  wire [CAP_W-1:0] fcc = learnedFullCapacityValue;
  wire flag = opStatusWord.learnQualifiedFlag;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // ==========================================
  // capacity and write-back
  // ==========================================
  sequence s_learned;
    $changed(fcc) && !$past(init) && !$past(init, 2);
  endsequence
  property p_rc_le_fcc;
    rc <= fcc;
  endproperty
  a_rc_le_fcc: assert property (p_rc_le_fcc)
    else $error("rc above fcc");
  property p_fcc_step;
    s_learned |-> fcc <= $past(fcc) + FCC_INC_LIM
      && fcc + FCC_DEC_LIM >= $past(fcc);
  endproperty
  a_fcc_step: assert property (p_fcc_step)
    else $error("fcc step too large");
  property p_wb_follow;
    s_learned |-> ##[1:8] nvWriteStrobe;
  endproperty
  a_wb_follow: assert property (p_wb_follow)
    else $error("no write-back");
  property p_wb_pulse;
    nvWriteStrobe |=> !nvWriteStrobe;
  endproperty
  a_wb_pulse: assert property (p_wb_pulse)
    else $error("write strobe too long");
  property p_init_load;
    init |-> ##[1:2] (fcc == storedFullCap && rc == CAP_ZERO);
  endproperty
  a_init_load: assert property (p_init_load)
    else $error("init load wrong");
  property p_sync;
    chargeTermination && gaugingConfig.capacitySyncEnable
      |-> ##[1:2] rc == fcc;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync missed");
  // ==========================================
  // cutoff and qualification flags
  // ==========================================
  property p_chg_clr;
    measTick && chargeDelta > 0 |-> ##[1:2] opStatusWord[2:0] == 3'h0;
  endproperty
  a_chg_clr: assert property (p_chg_clr)
    else $error("cutoff kept on charge");
  property p_cut_cause;
    $rose(opStatusWord.cutoff2) |-> $past(current) < 0
      && $past(current) >= -$signed({1'b0, overloadCurrent});
  endproperty
  a_cut_cause: assert property (p_cut_cause)
    else $error("cutoff without discharge");
  property p_flag_rise;
    $rose(flag) |-> $past(current) < 0;
  endproperty
  a_flag_rise: assert property (p_flag_rise)
    else $error("flag set without discharge");
  property p_flag_chg;
    measTick && chargeDelta >= $signed(VALID_CHG_UAH) |-> ##[1:2] !flag;
  endproperty
  a_flag_chg: assert property (p_flag_chg)
    else $error("flag kept on charge");
  property p_flag_temp;
    flag && measTick && temperature < learnMinTemp |-> ##[1:2] !flag;
  endproperty
  a_flag_temp: assert property (p_flag_temp)
    else $error("flag kept when cold");
  c_update: cover property (nvWriteStrobe);
  c_cut2: cover property ($rose(opStatusWord.cutoff2));
  c_qual: cover property ($rose(flag));
endmodule
bind clt_capacity_tracker clt_capacity_tracker_asserts #(
  .WB_CYCLES(WB_CYCLES)
) i_chk (
  .sys_clk, .nrst, .measTick, .init, .chargeDelta, .current,
  .temperature, .learnMinTemp, .overloadCurrent, .storedFullCap,
  .chargeTermination, .gaugingConfig, .remainingChargeCount,
  .learnedFullCapacityValue, .opStatusWord, .nvWriteStrobe
);
`default_nettype wire

/* File: sim/clt_capacity_tracker_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module clt_capacity_tracker_tb_top;
  import clt_pkg::*;
  logic sys_clk, nrst, measTick, init, chargeTermination, nvWriteStrobe;
  logic signed [CHG_W-1:0] chargeDelta;
  logic [CHG_W-1:0] selfDsgDelta;
  logic signed [CUR_W-1:0] current;
  logic signed [TEMP_W-1:0] temperature, learnMinTemp;
  logic [MV_W-1:0] cellVoltage;
  logic [CUR_W-1:0] overloadCurrent;
  logic [CAP_W-1:0] nearFullMargin, storedFullCap, designCapacitySetting;
  logic [CAP_W-1:0] remainingChargeCount, learnedFullCapacityValue;
  logic [CAP_W-1:0] designCapacityRef, nvWriteData;
  logic [PCT_W-1:0] lowChargePct, relativeSoc, absoluteSoc;
  clt_cfg_s gaugingConfig;
  clt_thr_s fixedThr, compThr;
  clt_status_s opStatusWord;
  int errors, check_count, seed, k;

  clt_capacity_tracker #(.WB_CYCLES(4)) i_dut (.sys_clk, .nrst, .measTick,
    .init, .chargeDelta, .selfDsgDelta, .current, .cellVoltage,
    .temperature, .learnMinTemp, .overloadCurrent, .nearFullMargin,
    .lowChargePct, .storedFullCap, .designCapacitySetting,
    .chargeTermination, .gaugingConfig, .fixedThr, .compThr,
    .remainingChargeCount, .learnedFullCapacityValue, .designCapacityRef,
    .relativeSoc, .absoluteSoc, .opStatusWord, .nvWriteStrobe,
    .nvWriteData);
  clt_nv_model i_nv (.sys_clk, .nrst, .wrStrobe(nvWriteStrobe),
    .wrData(nvWriteData), .storedCap(storedFullCap));

  // ==========================================
  // clock, tasks, watchdog
  // ==========================================
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one tick, inputs held until the next one
  task automatic tick(input int cd, input int cur, input int mv);
    chargeDelta = cd[CHG_W-1:0];
    current = cur[CUR_W-1:0];
    cellVoltage = mv[MV_W-1:0];
    measTick = 1'b1;
    @(posedge sys_clk);
    #10 measTick = 1'b0;
    repeat (2) @(posedge sys_clk);
    #10;
  endtask

  task automatic fill();
    repeat (8) tick(200000, 800, 4100);
  endtask

  initial begin
    #3000000;
    errors++;
    print_verdict();
  end

  // ==========================================
  // main sequence
  // ==========================================
  initial begin
    seed = 32'h099d;
    errors = 0;
    check_count = 0;
    {nrst, measTick, init, chargeTermination} = 4'h0;
    chargeDelta = '0;
    selfDsgDelta = '0;
    current = '0;
    cellVoltage = 16'h0e74;
    temperature = 16'h00fa;
    learnMinTemp = 16'h0064;
    overloadCurrent = 16'h05dc;
    nearFullMargin = 16'h0064;
    lowChargePct = 8'h0a;
    designCapacitySetting = 16'h044c;
    gaugingConfig = 4'h4;
    fixedThr = {16'h0af0, 16'h0b54, 16'h0bb8};
    compThr = {16'h0a8c, 16'h0bb8, 16'h0c1c};
    repeat (3) @(posedge sys_clk);
    #10 nrst = 1'b1;
    @(posedge sys_clk);
    #10 init = 1'b1;
    @(posedge sys_clk);
    #10 init = 1'b0;
    repeat (2) @(posedge sys_clk);
    #10 chk(learnedFullCapacityValue, 16'h03e8);
    fill();
    chk(remainingChargeCount, 16'h03e8);
    chk(relativeSoc, 8'h64);
    chk(absoluteSoc, 8'h5a);
    chk(designCapacityRef, 16'h044c);
    repeat (21) tick(-50000, -500, 3700);
    tick(-50000, -500, 2990);
    chk(opStatusWord.cutoff2, 1'b1);
    chk(learnedFullCapacityValue, 16'h044c);
    repeat (8) @(posedge sys_clk);
    #10 chk(storedFullCap, 16'h044c);
    gaugingConfig = 4'h0;
    fill();
    chk(opStatusWord, 4'h0);
    tick(-50000, -500, 3700);
    chk(opStatusWord.learnQualifiedFlag, 1'b1);
    repeat (9) tick(-50000, -500, 3700);
    tick(-50000, -500, 2990);
    chk(learnedFullCapacityValue, 16'h034c);
    fill();
    repeat (40) tick(-50000, -500, 3700);
    tick(-50000, -500, 2990);
    chk(learnedFullCapacityValue, 16'h054c);
    for (k = 0; k < 3; k++) begin
      fill();
      tick(-50000, -500, 3700);
      temperature = k == 0 ? 16'hfff6 : 16'h00fa;
      selfDsgDelta = k == 1 ? 24'h0493e0 : 24'h000000;
      tick(k == 2 ? 20000 : -50000, k == 2 ? 300 : -500, 3700);
      chk(opStatusWord.learnQualifiedFlag, 1'b0);
      temperature = 16'h00fa;
      selfDsgDelta = '0;
      if (k < 2) begin
        tick(-50000, -500, 2990);
        chk(learnedFullCapacityValue, 16'h054c);
      end
    end
    gaugingConfig = 4'h8;
    fill();
    repeat (4) tick(-50000, -500, 3700);
    chargeTermination = 1'b1;
    @(posedge sys_clk);
    #10 chargeTermination = 1'b0;
    repeat (2) @(posedge sys_clk);
    #10 chk(remainingChargeCount, 16'h054c);
    gaugingConfig = 4'h0;
    tick(200000, 800, 4100);
    tick(-1000, -10, 2700);
    chk(opStatusWord[2:0], 3'h0);
    tick(-50000, -2000, 2700);
    chk(opStatusWord[2:0], 3'h0);
    chk(opStatusWord.learnQualifiedFlag, 1'b0);
    tick(-50000, -500, 2700);
    chk(opStatusWord.cutoff0, 1'b1);
    chk(remainingChargeCount, 16'h0000);
    gaugingConfig = 4'h2;
    fill();
    tick(-50000, -500, 3050);
    chk(opStatusWord[2:0], 3'h1);
    gaugingConfig = 4'h3;
    fill();
    tick(-50000, -500, 2750);
    chk(opStatusWord[2:0], 3'h7);
    {gaugingConfig, lowChargePct} = {4'h0, 8'h00};
    fill();
    tick(-50000, -500, 2700);
    chk(opStatusWord[2:0], 3'h1);
    lowChargePct = 8'h0a;
    for (k = 0; k < 2; k++) begin
      fill();
      tick(-50000, -500, 3700);
      tick(-50000, k == 0 ? -50 : -500, k == 0 ? 2990 : 2700);
      chk(learnedFullCapacityValue, 16'h054c);
    end
    repeat (300) begin
      k = $random(seed);
      gaugingConfig = {k[3], 1'b0, k[1:0]};
      selfDsgDelta = {16'h0000, k[11:4]};
      temperature = {8'h00, k[19:12]} + 16'h0064;
      tick(k[31] ? -int'(k[15:0]) : int'(k[15:0]), k[31] ? -700 : 700,
        2600 + int'(k[26:16]));
    end
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: sim/clt_nv_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// stored capacity image seen by the gauge
// ==========================================
module clt_nv_model
  import clt_pkg::*;
#(
  parameter logic [CAP_W-1:0] INIT_CAP = 16'h03e8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wrStrobe,
  input wire logic [CAP_W-1:0] wrData,
  output logic [CAP_W-1:0] storedCap
);
  // image reloads at power-up, then follows each write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      storedCap <= INIT_CAP;
    end else if (wrStrobe) begin
      storedCap <= wrData;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/clt_capacity_tracker.sv */
`timescale 1ns/10ps
`default_nettype none
module clt_capacity_tracker
  import clt_pkg::*;
#(
  parameter int WB_CYCLES = WB_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic measTick,
  input wire logic init,
  input wire logic signed [CHG_W-1:0] chargeDelta,
  input wire logic [CHG_W-1:0] selfDsgDelta,
  input wire logic signed [CUR_W-1:0] current,
  input wire logic [MV_W-1:0] cellVoltage,
  input wire logic signed [TEMP_W-1:0] temperature,
  input wire logic signed [TEMP_W-1:0] learnMinTemp,
  input wire logic [CUR_W-1:0] overloadCurrent,
  input wire logic [CAP_W-1:0] nearFullMargin,
  input wire logic [PCT_W-1:0] lowChargePct,
  input wire logic [CAP_W-1:0] storedFullCap,
  input wire logic [CAP_W-1:0] designCapacitySetting,
  input wire logic chargeTermination,
  input wire clt_cfg_s gaugingConfig,
  input wire clt_thr_s fixedThr,
  input wire clt_thr_s compThr,
  output logic [CAP_W-1:0] remainingChargeCount,
  output logic [CAP_W-1:0] learnedFullCapacityValue,
  output logic [CAP_W-1:0] designCapacityRef,
  output logic [PCT_W-1:0] relativeSoc,
  output logic [PCT_W-1:0] absoluteSoc,
  output clt_status_s opStatusWord,
  output logic nvWriteStrobe,
  output logic [CAP_W-1:0] nvWriteData
);
  // ==========================================
  // state
  // ==========================================
  logic [CAP_W-1:0] rc_r, rc_nxt;
  logic [CAP_W-1:0] fcc_r, fcc_nxt;
  logic [CAP_W-1:0] dsgCap_r, dsgCap_nxt;
  logic [CHG_W-1:0] dsgUah_r, dsgUah_nxt;
  logic [CHG_W-1:0] chgAcc_r, chgAcc_nxt;
  logic [CHG_W-1:0] selfAcc_r, selfAcc_nxt;
  logic [2:0] edv_r, edv_nxt;
  logic vdq_r, vdq_nxt;
  logic upd_r, upd_nxt;
  clt_learn_e ls_r, ls_nxt;
  logic [PCT_W-1:0] rsoc_r, rsoc_nxt, asoc_r, asoc_nxt;
  clt_thr_s thr;

  clt_threshold_sel u_thr (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .cfg(gaugingConfig),
    .fixedThr(fixedThr),
    .compThr(compThr),
    .thr(thr)
  );

  clt_writeback #(.WB_CYCLES(WB_CYCLES)) u_wb (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .updated(upd_r),
    .value(fcc_r),
    .wrStrobe(nvWriteStrobe),
    .wrData(nvWriteData)
  );

  // ==========================================
  // derived quantities
  // ==========================================
  logic [CUR_W-1:0] dsgMag;
  logic [CUR_W-1:0] cOver32;
  logic [CUR_W+1:0] c3Over32;
  logic dsgActive, chgActive, overload, detectOk;
  logic [CAP_W+PCT_W-1:0] lowProd, lvl1Prod;
  logic [CAP_W-1:0] lowCap, lvl1Cap;
  logic [2:0] hit;

  always_comb begin
    dsgMag = current[CUR_W-1] ? CUR_W'(-current) : '0;
    cOver32 = fcc_r >> RATE_SHIFT;
    c3Over32 = (CUR_W+2)'((RATE_MULT * fcc_r) >> RATE_SHIFT);
    dsgActive = current[CUR_W-1];
    chgActive = !current[CUR_W-1] && (current != '0);
    overload = dsgMag > overloadCurrent;
    detectOk = dsgActive && !overload && (dsgMag >= cOver32);
    lowProd = fcc_r * lowChargePct;
    lvl1Prod = fcc_r * LVL1_PCT;
    lowCap = CAP_W'(lowProd / PCT_FULL);
    lvl1Cap = CAP_W'(lvl1Prod / PCT_FULL);
    hit[0] = cellVoltage <= thr.lvl0;
    hit[1] = cellVoltage <= thr.lvl1;
    hit[2] = cellVoltage <= thr.lvl2;
  end

  // ==========================================
  // counters, learning and cutoffs
  // ==========================================
  logic [CAP_W:0] sumUp;
  logic [CAP_W-1:0] newFcc;
  logic [CHG_W-1:0] negUah, selfSum;
  logic [CHG_W-1:0] chgSum;
  logic [CAP_W-1:0] subMah;

  always_comb begin
    rc_nxt = rc_r;
    fcc_nxt = fcc_r;
    dsgCap_nxt = dsgCap_r;
    dsgUah_nxt = dsgUah_r;
    chgAcc_nxt = chgAcc_r;
    selfAcc_nxt = selfAcc_r;
    edv_nxt = edv_r;
    vdq_nxt = vdq_r;
    upd_nxt = 1'b0;
    ls_nxt = ls_r;
    newFcc = fcc_r;
    sumUp = '0;
    negUah = '0;
    selfSum = '0;
    chgSum = '0;
    subMah = '0;
    if (init) begin
      fcc_nxt = storedFullCap;
      rc_nxt = CAP_ZERO;
      ls_nxt = LS_IDLE;
      vdq_nxt = 1'b0;
      edv_nxt = '0;
    end else if (measTick) begin
      // charge side, whole mAh added to rc_r, sub-mAh remainder carried in dsgUah_r
      if (!chargeDelta[CHG_W-1]) begin
        chgSum = dsgUah_r + CHG_W'(chargeDelta);
        subMah = CAP_W'(chgSum / UAH_PER_MAH);
        dsgUah_nxt = chgSum % UAH_PER_MAH;
        sumUp = {1'b0, rc_r} + {1'b0, subMah};
        rc_nxt = (sumUp > {1'b0, fcc_r}) ? fcc_r : sumUp[CAP_W-1:0];
        chgAcc_nxt = chgAcc_r + CHG_W'(chargeDelta);
        if (chargeDelta != '0) begin
          edv_nxt = '0;
        end
        if (chgAcc_nxt >= VALID_CHG_UAH) begin
          vdq_nxt = 1'b0;
          ls_nxt = LS_IDLE;
        end
      end else begin
        negUah = CHG_W'(-chargeDelta);
      end
      // self-discharge applies on top of this tick's charge result
      selfSum = negUah + selfDsgDelta + dsgUah_nxt;
      if (chargeDelta[CHG_W-1] || selfDsgDelta != '0) begin
        subMah = CAP_W'(selfSum / UAH_PER_MAH);
        dsgUah_nxt = selfSum % UAH_PER_MAH;
        rc_nxt = (subMah >= rc_nxt) ? CAP_ZERO : rc_nxt - subMah;
        if (ls_r == LS_RUN) begin
          dsgCap_nxt = dsgCap_r + subMah;
        end
      end
      if (ls_r == LS_RUN) begin
        selfAcc_nxt = selfAcc_r + selfDsgDelta;
        if (selfAcc_nxt > SELF_DSG_LIM_UAH) begin
          vdq_nxt = 1'b0;
          ls_nxt = LS_IDLE;
        end
        if (temperature < learnMinTemp) begin
          vdq_nxt = 1'b0;
          ls_nxt = LS_IDLE;
        end
        if (overload && rc_nxt <= lowCap) begin
          vdq_nxt = 1'b0;
          ls_nxt = LS_IDLE;
        end
      end
      // discharge start qualification
      if (dsgActive && ls_r != LS_RUN && !edv_r[2]
          && rc_r >= fcc_r - nearFullMargin) begin
        ls_nxt = LS_RUN;
        vdq_nxt = 1'b1;
        dsgCap_nxt = fcc_r - rc_r;
        chgAcc_nxt = '0;
        selfAcc_nxt = '0;
      end
      // cutoff detection and corrections
      if (detectOk) begin
        if (hit[2] && !edv_r[2]) begin
          edv_nxt[2] = 1'b1;
          if (rc_nxt > lowCap) begin
            rc_nxt = lowCap;
          end
          if (ls_r == LS_RUN && vdq_r) begin
            if (cellVoltage + CUTOFF_LEVEL_2_MARGIN_MV >= thr.lvl2
                && {2'b00, dsgMag} >= c3Over32) begin
              newFcc = dsgCap_nxt + lowCap;
              if (newFcc + FCC_DEC_LIM < fcc_r) begin
                newFcc = fcc_r - FCC_DEC_LIM;
              end else if (newFcc > fcc_r + FCC_INC_LIM) begin
                newFcc = fcc_r + FCC_INC_LIM;
              end
              if (gaugingConfig.learnCapLimitEnable
                  && newFcc > designCapacitySetting) begin
                newFcc = designCapacitySetting;
              end
              if (newFcc > MAX_CAP_MAH) begin
                newFcc = MAX_CAP_MAH;
              end
              fcc_nxt = newFcc;
              upd_nxt = 1'b1;
            end
            vdq_nxt = 1'b0;
            ls_nxt = LS_DONE;
          end
        end
        if (lowChargePct != '0) begin
          if (hit[1] && !edv_r[1]) begin
            edv_nxt[1] = 1'b1;
            if (rc_nxt > lvl1Cap) begin
              rc_nxt = lvl1Cap;
            end
          end
          if (hit[0] && !edv_r[0]) begin
            edv_nxt[0] = 1'b1;
            rc_nxt = CAP_ZERO;
          end
        end
      end else if (overload && hit[2] && ls_r == LS_RUN) begin
        vdq_nxt = 1'b0;
        ls_nxt = LS_IDLE;
      end
      if (ls_r == LS_DONE && chgActive) begin
        ls_nxt = LS_IDLE;
      end
    end
    if (chargeTermination && gaugingConfig.capacitySyncEnable) begin
      rc_nxt = fcc_nxt;
    end
  end

  // ==========================================
  // state of charge, relative vs absolute
  // ==========================================
  logic [CAP_W+PCT_W-1:0] rcPct;
  always_comb begin
    rcPct = rc_r * PCT_FULL;
    rsoc_nxt = (fcc_r == '0) ? '0 : PCT_W'(rcPct / fcc_r);
    asoc_nxt = (designCapacitySetting == '0) ? '0
               : PCT_W'(rcPct / designCapacitySetting);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rc_r <= '0;
      fcc_r <= '0;
      dsgCap_r <= '0;
      dsgUah_r <= '0;
      chgAcc_r <= '0;
      selfAcc_r <= '0;
      edv_r <= '0;
      vdq_r <= 1'b0;
      upd_r <= 1'b0;
      ls_r <= LS_IDLE;
      rsoc_r <= '0;
      asoc_r <= '0;
    end else begin
      rc_r <= rc_nxt;
      fcc_r <= fcc_nxt;
      dsgCap_r <= dsgCap_nxt;
      dsgUah_r <= dsgUah_nxt;
      chgAcc_r <= chgAcc_nxt;
      selfAcc_r <= selfAcc_nxt;
      edv_r <= edv_nxt;
      vdq_r <= vdq_nxt;
      upd_r <= upd_nxt;
      ls_r <= ls_nxt;
      rsoc_r <= rsoc_nxt;
      asoc_r <= asoc_nxt;
    end
  end

  // design capacity reference registered for a flop-driven output
  logic [CAP_W-1:0] dcRef_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dcRef_r <= '0;
    end else begin
      dcRef_r <= designCapacitySetting;
    end
  end

  assign remainingChargeCount = rc_r;
  assign learnedFullCapacityValue = fcc_r;
  assign designCapacityRef = dcRef_r;
  assign relativeSoc = rsoc_r;
  assign absoluteSoc = asoc_r;
  assign opStatusWord = '{learnQualifiedFlag: vdq_r, cutoff0: edv_r[0],
                          cutoff1: edv_r[1], cutoff2: edv_r[2]};
endmodule
`default_nettype wire

/* File: verilog/clt_pkg.sv */
package clt_pkg;
  // ==========================================
  // widths and fixed figures
  // ==========================================
  localparam int CAP_W = 16;     // mAh, covers 32 Ah
  localparam int CHG_W = 24;     // signed increments in uAh
  localparam int MV_W = 16;
  localparam int TEMP_W = 16;
  localparam int CUR_W = 16;     // mA, discharge negative
  localparam int PCT_W = 8;
  localparam logic [CAP_W-1:0] MAX_CAP_MAH = 16'h7d00;   // 32000 mAh
  localparam logic [CAP_W-1:0] CAP_ZERO = 16'h0000;
  localparam logic [CHG_W-1:0] VALID_CHG_UAH = 24'h002710;  // 10 mAh
  localparam logic [CHG_W-1:0] SELF_DSG_LIM_UAH = 24'h03e800; // 256 mAh
  localparam logic [CHG_W-1:0] UAH_PER_MAH = 24'h0003e8;
  localparam logic [MV_W-1:0] CUTOFF_LEVEL_2_MARGIN_MV = 16'h0100;  // 256 mV
  localparam logic [CAP_W-1:0] FCC_DEC_LIM = 16'h0100;    // 256 mAh
  localparam logic [CAP_W-1:0] FCC_INC_LIM = 16'h0200;    // 512 mAh
  localparam logic [PCT_W-1:0] LVL1_PCT = 8'h03;
  localparam logic [PCT_W-1:0] PCT_FULL = 8'h64;
  localparam int RATE_SHIFT = 5;  // C/32
  localparam int RATE_MULT = 3;   // 3C/32
  localparam real WB_TIME_S = 4.0;
  localparam real CLK_HZ = 10.0e6;
  localparam int WB_CYC = int'(WB_TIME_S * CLK_HZ);

  // ==========================================
  // carriers
  // ==========================================
  typedef struct packed {
    logic capacitySyncEnable;
    logic learnCapLimitEnable;
    logic thresholdCompEnable;
    logic fixedFloorEnable;
  } clt_cfg_s;

  typedef struct packed {
    logic [MV_W-1:0] lvl0;
    logic [MV_W-1:0] lvl1;
    logic [MV_W-1:0] lvl2;
  } clt_thr_s;

  typedef struct packed {
    logic learnQualifiedFlag;
    logic cutoff0;
    logic cutoff1;
    logic cutoff2;
  } clt_status_s;

  typedef enum logic [1:0] {LS_IDLE, LS_RUN, LS_DONE} clt_learn_e;
endpackage

/* File: verilog/clt_threshold_sel.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// cutoff threshold selection
// ==========================================
module clt_threshold_sel
  import clt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire clt_cfg_s cfg,
  input wire clt_thr_s fixedThr,
  input wire clt_thr_s compThr,
  output clt_thr_s thr
);
  clt_thr_s thr_r;
  clt_thr_s thr_nxt;

  always_comb begin
    thr_nxt = fixedThr;
    if (cfg.thresholdCompEnable) begin
      thr_nxt = compThr;
      if (cfg.fixedFloorEnable) begin
        thr_nxt.lvl0 = fixedThr.lvl0;
        if (compThr.lvl1 < fixedThr.lvl0) begin
          thr_nxt.lvl1 = fixedThr.lvl0;
        end
        if (compThr.lvl2 < fixedThr.lvl0) begin
          thr_nxt.lvl2 = fixedThr.lvl0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      thr_r <= '0;
    end else begin
      thr_r <= thr_nxt;
    end
  end

  assign thr = thr_r;
endmodule
`default_nettype wire

/* File: verilog/clt_writeback.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// learned capacity write-back timer
// ==========================================
module clt_writeback
  import clt_pkg::*;
#(
  parameter int WB_CYCLES = WB_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic updated,
  input wire logic [CAP_W-1:0] value,
  output logic wrStrobe,
  output logic [CAP_W-1:0] wrData
);
  localparam int CW = $clog2(WB_CYCLES + 1);
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic pend_r, pend_nxt;
  logic stb_r, stb_nxt;
  logic [CAP_W-1:0] dat_r, dat_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    pend_nxt = pend_r;
    stb_nxt = 1'b0;
    dat_nxt = dat_r;
    if (pend_r) begin
      cnt_nxt = CW'(cnt_r + 1'b1);
      // back-to-back updates must not starve the write past the limit
      if (!updated || cnt_r >= CW'(WB_CYCLES - 1)) begin
        stb_nxt = 1'b1;
        pend_nxt = 1'b0;
        cnt_nxt = '0;
      end
    end
    if (updated) begin
      pend_nxt = 1'b1;
      dat_nxt = value;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      pend_r <= 1'b0;
      stb_r <= 1'b0;
      dat_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
      stb_r <= stb_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wrStrobe = stb_r;
  assign wrData = dat_r;
endmodule
`default_nettype wire
